//--- cpu_exec_map.vh
// Constants for the stack, byte load, branch and bit-operation execution unit
// Notes on behaviour
// - Push writes register at stack_pointer, then adds two
// - Wide push stores low half, then zero-extended extension
// - Pop subtracts two, then loads word at stack_pointer
// - Short byte access: base plus 0..15, R0..R7
// - Byte load zero-extends; byte store writes low byte
// - Long byte access adds 0..FFFFh to base
// - Fixed-base byte access moves R0 at base+0..255
// - Indexed byte access adds zero-extended index to base
// - Program-memory load reads word at address register
// - Short immediate zero-extends; wide immediates load whole
// - Delayed call saves PC+4, slot, then jumps relative
// - Delay slot sees the already saved link value
// - Relative branch: always, test set, test clear
// - Delay slot runs before branch decision and jump
// - External-condition branch selects one of four inputs
// - Loop branch decrements counter, flag, slot, branch
// - Absolute jumps take 22-bit target; call saves PC+4
// - Indirect jumps use address register; call saves PC+2
// - Delayed return runs slot, then goes to link
// - Bit clear/set/complement rewrite byte at base+R1
// - Bit test writes nothing; sets test flag if zero
`ifndef CPU_EXEC_MAP_VH
`define CPU_EXEC_MAP_VH

// Operation codes presented on op_in
`define OP_NOP       5'h00
`define OP_PUSH      5'h01
`define OP_POP       5'h02
`define OP_PUSHA     5'h03
`define OP_POPA      5'h04
`define OP_LDB_D4    5'h05
`define OP_STB_D4    5'h06
`define OP_LDB_D16   5'h07
`define OP_STB_D16   5'h08
`define OP_LDB_BASE  5'h09
`define OP_STB_BASE  5'h0A
`define OP_LDB_IDX   5'h0B
`define OP_STB_IDX   5'h0C
`define OP_LDC       5'h0D
`define OP_LDI8      5'h0E
`define OP_LDI16     5'h0F
`define OP_LDI22     5'h10
`define OP_DELAYED_SUBROUTINE_BRANCH      5'h11
`define OP_BR        5'h12
`define OP_BRD       5'h13
`define OP_BREC      5'h14
`define OP_BRECD     5'h15
`define OP_LOOP_BRANCH      5'h16
`define OP_JMPA      5'h17
`define OP_JMPI      5'h18
`define OP_DELAYED_RETURN      5'h19
`define OP_BIT_CLEAR      5'h1A
`define OP_BITS      5'h1B
`define OP_BIT_COMPLEMENT      5'h1C
`define OP_BIT_TEST      5'h1D

// Condition field of branches and jumps
`define COND_ALWAYS  2'h0
`define COND_TSET    2'h1
`define COND_TCLR    2'h2
`define COND_CALL    2'h3

// Kinds of pending delayed branch
`define PK_ALWAYS    3'h0
`define PK_TSET      3'h1
`define PK_TCLR      3'h2
`define PK_ZA_CLR    3'h3
`define PK_ZB_CLR    3'h4
`define PK_NEVER     3'h5

// Register indexes and offset field widths
`define IDX_SP       4'hF
`define IDX_LINK     4'hE
`define IDX_LOOPA    4'h6
`define IDX_LOOPB    4'h7
`define OFFW_DELAYED_SUBROUTINE_BRANCH    4'd12
`define OFFW_BR      4'd10
`define OFFW_SHORT   4'd7

// Reset values
`define PC_RESET     22'h000000
`define SP_RESET     22'h000000

`endif

//--- cpu_exec_unit.v
// Execution unit for stack, byte load, branch and bit operations
`timescale 1ns/1ps
`include "cpu_exec_map.vh"

module cpu_exec_unit (
  // Clock and reset
  input  wire        mclk_in,
  input  wire        resetn_in,
  // Decoded instruction
  input  wire        instr_valid_in,
  input  wire [4:0]  op_in,
  input  wire [1:0]  cond_in,
  input  wire        pair_in,
  input  wire [3:0]  rn_in,
  input  wire [3:0]  rm_in,
  input  wire [2:0]  ai_in,
  input  wire [21:0] imm_in,
  output wire        ready_out,
  output wire        retire_out,
  // Data memory
  output wire [21:0] dmem_addr_out,
  output wire [15:0] dmem_wdata_out,
  output wire        dmem_re_out,
  output wire        dmem_we_out,
  output wire        dmem_byte_out,
  input  wire [15:0] dmem_rdata_in,
  // Program memory
  output wire [21:0] pmem_addr_out,
  output wire        pmem_re_out,
  input  wire [15:0] pmem_rdata_in,
  // External conditions and test flag load
  input  wire [3:0]  ext_cond_in,
  input  wire        tflag_load_in,
  input  wire        tflag_val_in,
  // Status and observation
  input  wire [3:0]  reg_sel_in,
  output wire [15:0] gpr_val_out,
  output wire [5:0]  ext_val_out,
  output wire [21:0] pc_out,
  output wire        test_flag_out,
  output wire        loop_zero_a_out,
  output wire        loop_zero_b_out
);

  // Sequencer states
  localparam [1:0] S_IDLE  = 2'b00;
  localparam [1:0] S_EXEC  = 2'b01;
  localparam [1:0] S_ACC   = 2'b10;
  localparam [1:0] S_RDATA = 2'b11;

  reg [15:0] gpr_ff [0:15];           // General registers
  reg [5:0]  ext_ff [0:7];            // Extension registers of A8..A15
  reg [1:0]  state_ff;                // Sequencer state
  reg        ready_ff;                // Accepting an instruction
  reg        retire_ff;               // Instruction finished pulse
  reg [1:0]  step_ff;                 // Memory step within instruction
  reg [4:0]  op_ff;                   // Latched operation
  reg [1:0]  cond_ff;                 // Latched condition
  reg        pair_ff;                 // Latched pair flag
  reg [3:0]  rn_ff;                   // Latched first register
  reg [3:0]  rm_ff;                   // Latched second register
  reg [2:0]  ai_ff;                   // Latched address register
  reg [21:0] imm_ff;                  // Latched immediate or offset
  reg [21:0] dmem_addr_ff;            // Data memory address
  reg [15:0] dmem_wdata_ff;           // Data memory write data
  reg        dmem_re_ff;              // Data memory read strobe
  reg        dmem_we_ff;              // Data memory write strobe
  reg        dmem_byte_ff;            // Byte-wide access
  reg [21:0] pmem_addr_ff;            // Program memory address
  reg        pmem_re_ff;              // Program memory read strobe
  reg        prog_ff;                 // Pending read is program memory
  reg [3:0]  ec_meta_ff;              // External condition, first stage
  reg [3:0]  ec_sync_ff;              // External condition, second stage
  reg        test_flag_ff;            // Test flag
  reg        zero_a_ff;               // Loop counter a zero flag
  reg        zero_b_ff;               // Loop counter b zero flag
  reg [21:0] pc_ff;                   // Program counter
  reg        pend_ff;                 // Delayed branch awaiting its slot
  reg [2:0]  pend_kind_ff;            // Decision kind of pending branch
  reg [21:0] pend_tgt_ff;             // Target of pending branch
  reg [15:0] gpr_val_ff;              // Observed general register
  reg [5:0]  ext_val_ff;              // Observed extension register

  // Combinational helpers
  reg [21:0] base22;                  // Named address register
  reg [21:0] sp22;                    // Stack pointer
  reg [21:0] link22;                  // Link register
  reg [21:0] a8_22;                   // Byte base register
  reg [21:0] byte_addr;               // Byte access address
  reg [3:0]  byte_reg;                // Byte access data register
  reg        wide;                    // Wide push or pop
  reg [1:0]  last_step;               // Index of final step
  reg [3:0]  item_reg;                // Register of current stack step
  reg        item_ext;                // Current step moves extension
  reg [15:0] push_data;               // Word pushed this step
  reg [2:0]  ilen;                    // Instruction length in bytes
  reg [21:0] br_tgt;                  // Branch target
  reg        br_now;                  // Undelayed branch taken
  reg        delayed;                 // Branch with delay slot
  reg [2:0]  pkind;                   // Decision kind for delayed branch
  reg [15:0] dec_val;                 // Decremented loop counter
  reg [7:0]  bit_new;                 // Modified byte for bit ops
  reg        bit_old;                 // Selected bit of read byte
  reg        finish;                  // Instruction ends this cycle
  reg        t_eff;                   // Test flag as the slot leaves it
  reg        pend_go;                 // Pending branch decision

  // Shifted, sign-extended branch offset from a w-bit field
  function [21:0] off22;
    input [21:0] f;
    input [3:0]  w;
    integer i;
    reg [21:0] v;
    begin
      v = 22'h000000;
      for (i = 0; i < 21; i = i + 1) begin
        if (i < w)
          v[i + 1] = f[i];
        else
          v[i + 1] = f[w - 1];
      end
      off22 = v;
    end
  endfunction

  // Condition test against the test flag
  function cond_ok;
    input [1:0] c;
    input       t;
    begin
      case (c)
        `COND_TSET: cond_ok = t;
        `COND_TCLR: cond_ok = ~t;
        default:    cond_ok = 1'b1;
      endcase
    end
  endfunction

  // Operand, address and branch decode
  always @* begin
    base22    = {ext_ff[ai_ff], gpr_ff[{1'b1, ai_ff}]};
    sp22      = {ext_ff[3'h7], gpr_ff[`IDX_SP]};
    link22    = {ext_ff[3'h6], gpr_ff[`IDX_LINK]};
    a8_22     = {ext_ff[3'h0], gpr_ff[4'h8]};
    byte_reg  = {1'b0, rn_ff[2:0]};
    case (op_ff)
      `OP_LDB_D4, `OP_STB_D4:     byte_addr = base22 + {18'h00000, imm_ff[3:0]};
      `OP_LDB_D16, `OP_STB_D16:   byte_addr = base22 + {6'h00, imm_ff[15:0]};
      `OP_LDB_BASE, `OP_STB_BASE: byte_addr = a8_22 + {14'h0000, imm_ff[7:0]};
      `OP_LDB_IDX, `OP_STB_IDX:   byte_addr = base22 + {6'h00, gpr_ff[rm_ff]};
      default:                    byte_addr = a8_22 + {6'h00, gpr_ff[4'h1]};
    endcase
    if (op_ff == `OP_LDB_BASE || op_ff == `OP_STB_BASE)
      byte_reg = 4'h0;
    wide      = (op_ff == `OP_PUSHA) || (op_ff == `OP_POPA);
    last_step = wide ? (pair_ff ? 2'd3 : 2'd1) : {1'b0, pair_ff};
    if (wide) begin
      item_reg = step_ff[1] ? {1'b1, rm_ff[2:0]} : {1'b1, rn_ff[2:0]};
      item_ext = (op_ff == `OP_PUSHA) ? step_ff[0] : ~step_ff[0];
    end else begin
      item_reg = step_ff[0] ? rm_ff : rn_ff;
      item_ext = 1'b0;
    end
    push_data = item_ext ? {10'h000, ext_ff[item_reg[2:0]]} : gpr_ff[item_reg];
    case (op_ff)
      `OP_LDI16, `OP_LDI22, `OP_LDB_D16, `OP_STB_D16, `OP_JMPA: ilen = 3'd4;
      default: ilen = 3'd2;
    endcase
    dec_val = gpr_ff[cond_ff[0] ? `IDX_LOOPB : `IDX_LOOPA] - 16'h0001;
    br_now  = 1'b0;
    delayed = 1'b0;
    pkind   = `PK_ALWAYS;
    case (op_ff)
      `OP_DELAYED_SUBROUTINE_BRANCH: begin
        br_tgt  = pc_ff + 22'h000002 + off22(imm_ff, `OFFW_DELAYED_SUBROUTINE_BRANCH);
        delayed = 1'b1;
      end
      `OP_BR, `OP_BRD: begin
        br_tgt  = pc_ff + 22'h000002 + off22(imm_ff, `OFFW_BR);
        br_now  = (op_ff == `OP_BR) && cond_ok(cond_ff, test_flag_ff);
        delayed = (op_ff == `OP_BRD);
        pkind   = (cond_ff == `COND_TSET) ? `PK_TSET :
                  (cond_ff == `COND_TCLR) ? `PK_TCLR : `PK_ALWAYS;
      end
      `OP_BREC, `OP_BRECD: begin
        br_tgt  = pc_ff + 22'h000002 + off22(imm_ff, `OFFW_SHORT);
        br_now  = (op_ff == `OP_BREC) && ec_sync_ff[cond_ff];
        delayed = (op_ff == `OP_BRECD);
        pkind   = ec_sync_ff[cond_ff] ? `PK_ALWAYS : `PK_NEVER;
      end
      `OP_LOOP_BRANCH: begin
        br_tgt  = pc_ff + 22'h000002 + off22(imm_ff, `OFFW_SHORT);
        delayed = 1'b1;
        pkind   = cond_ff[0] ? `PK_ZB_CLR : `PK_ZA_CLR;
      end
      `OP_JMPA: begin
        br_tgt = imm_ff;
        br_now = cond_ok(cond_ff, test_flag_ff);
      end
      `OP_JMPI: begin
        br_tgt = base22;
        br_now = cond_ok(cond_ff, test_flag_ff);
      end
      `OP_DELAYED_RETURN: begin
        br_tgt  = link22;
        delayed = 1'b1;
      end
      default: br_tgt = pc_ff;
    endcase
    bit_old = dmem_rdata_in[imm_ff[2:0]];
    bit_new = dmem_rdata_in[7:0];
    case (op_ff)
      `OP_BIT_CLEAR: bit_new[imm_ff[2:0]] = 1'b0;
      `OP_BITS: bit_new[imm_ff[2:0]] = 1'b1;
      `OP_BIT_COMPLEMENT: bit_new[imm_ff[2:0]] = ~bit_old;
      default:  bit_new[imm_ff[2:0]] = bit_old;
    endcase
    case (state_ff)
      S_EXEC:  finish = (op_ff >= `OP_LDI8 && op_ff <= `OP_DELAYED_RETURN && op_ff != `OP_LDC) ||
                        (op_ff == `OP_NOP);
      S_ACC:   finish = dmem_we_ff && (step_ff == last_step);
      S_RDATA: finish = (step_ff == last_step) &&
                        !(op_ff == `OP_BIT_CLEAR || op_ff == `OP_BITS || op_ff == `OP_BIT_COMPLEMENT);
      default: finish = 1'b0;
    endcase
    t_eff = (state_ff == S_RDATA && op_ff == `OP_BIT_TEST) ? ~bit_old : test_flag_ff;
    case (pend_kind_ff)
      `PK_TSET:   pend_go = t_eff;
      `PK_TCLR:   pend_go = ~t_eff;
      `PK_ZA_CLR: pend_go = ~zero_a_ff;
      `PK_ZB_CLR: pend_go = ~zero_b_ff;
      `PK_NEVER:  pend_go = 1'b0;
      default:    pend_go = 1'b1;
    endcase
  end

  // Sequencer, register file and memory strobes
  always @(posedge mclk_in) begin : seq
    integer i;
    if (!resetn_in) begin
      for (i = 0; i < 16; i = i + 1) begin
        gpr_ff[i] <= 16'h0000;
      end
      for (i = 0; i < 8; i = i + 1) begin
        ext_ff[i] <= 6'h00;
      end
      {ext_ff[3'h7], gpr_ff[`IDX_SP]} <= `SP_RESET;
      state_ff      <= S_IDLE;
      ready_ff      <= 1'b1;
      retire_ff     <= 1'b0;
      step_ff       <= 2'd0;
      op_ff         <= `OP_NOP;
      cond_ff       <= 2'h0;
      pair_ff       <= 1'b0;
      rn_ff         <= 4'h0;
      rm_ff         <= 4'h0;
      ai_ff         <= 3'h0;
      imm_ff        <= 22'h000000;
      dmem_addr_ff  <= 22'h000000;
      dmem_wdata_ff <= 16'h0000;
      dmem_re_ff    <= 1'b0;
      dmem_we_ff    <= 1'b0;
      dmem_byte_ff  <= 1'b0;
      pmem_addr_ff  <= 22'h000000;
      pmem_re_ff    <= 1'b0;
      prog_ff       <= 1'b0;
      ec_meta_ff    <= 4'h0;
      ec_sync_ff    <= 4'h0;
      test_flag_ff  <= 1'b0;
      zero_a_ff     <= 1'b0;
      zero_b_ff     <= 1'b0;
      gpr_val_ff    <= 16'h0000;
      ext_val_ff    <= 6'h00;
    end else begin
      ec_meta_ff <= ext_cond_in;
      ec_sync_ff <= ec_meta_ff;
      gpr_val_ff <= gpr_ff[reg_sel_in];
      ext_val_ff <= ext_ff[reg_sel_in[2:0]];
      retire_ff  <= finish;
      dmem_re_ff <= 1'b0;
      dmem_we_ff <= 1'b0;
      pmem_re_ff <= 1'b0;
      if (tflag_load_in)
        test_flag_ff <= tflag_val_in;
      case (state_ff)
        // Take a new instruction
        S_IDLE: begin
          if (instr_valid_in) begin
            op_ff    <= op_in;
            cond_ff  <= cond_in;
            pair_ff  <= pair_in;
            rn_ff    <= rn_in;
            rm_ff    <= rm_in;
            ai_ff    <= ai_in;
            imm_ff   <= imm_in;
            step_ff  <= 2'd0;
            ready_ff <= 1'b0;
            state_ff <= S_EXEC;
          end
        end
        // Issue an access or complete a register-only operation
        S_EXEC: begin
          state_ff <= S_ACC;
          prog_ff  <= 1'b0;
          case (op_ff)
            `OP_PUSH, `OP_PUSHA: begin
              dmem_addr_ff  <= sp22;
              dmem_wdata_ff <= push_data;
              dmem_we_ff    <= 1'b1;
              dmem_byte_ff  <= 1'b0;
            end
            `OP_POP, `OP_POPA: begin
              {ext_ff[3'h7], gpr_ff[`IDX_SP]} <= sp22 - 22'h000002;
              dmem_addr_ff <= sp22 - 22'h000002;
              dmem_re_ff   <= 1'b1;
              dmem_byte_ff <= 1'b0;
            end
            `OP_LDB_D4, `OP_LDB_D16, `OP_LDB_BASE, `OP_LDB_IDX, `OP_BIT_CLEAR, `OP_BITS, `OP_BIT_COMPLEMENT, `OP_BIT_TEST: begin
              dmem_addr_ff <= byte_addr;
              dmem_re_ff   <= 1'b1;
              dmem_byte_ff <= 1'b1;
            end
            `OP_STB_D4, `OP_STB_D16, `OP_STB_BASE, `OP_STB_IDX: begin
              dmem_addr_ff  <= byte_addr;
              dmem_wdata_ff <= {8'h00, gpr_ff[byte_reg][7:0]};
              dmem_we_ff    <= 1'b1;
              dmem_byte_ff  <= 1'b1;
            end
            `OP_LDC: begin
              pmem_addr_ff <= base22;
              pmem_re_ff   <= 1'b1;
              prog_ff      <= 1'b1;
            end
            default: begin
              state_ff <= S_IDLE;
              ready_ff <= 1'b1;
              case (op_ff)
                `OP_LDI8:  gpr_ff[rn_ff] <= {8'h00, imm_ff[7:0]};
                `OP_LDI16: gpr_ff[rn_ff] <= imm_ff[15:0];
                `OP_LDI22: {ext_ff[rn_ff[2:0]], gpr_ff[{1'b1, rn_ff[2:0]}]} <= imm_ff;
                `OP_DELAYED_SUBROUTINE_BRANCH:  {ext_ff[3'h6], gpr_ff[`IDX_LINK]} <= pc_ff + 22'h000004;
                `OP_JMPA: begin
                  if (cond_ff == `COND_CALL)
                    {ext_ff[3'h6], gpr_ff[`IDX_LINK]} <= pc_ff + 22'h000004;
                end
                `OP_JMPI: begin
                  if (cond_ff == `COND_CALL)
                    {ext_ff[3'h6], gpr_ff[`IDX_LINK]} <= pc_ff + 22'h000002;
                end
                `OP_LOOP_BRANCH: begin
                  if (cond_ff[0]) begin
                    gpr_ff[`IDX_LOOPB] <= dec_val;
                    zero_b_ff          <= (dec_val == 16'h0000);
                  end else begin
                    gpr_ff[`IDX_LOOPA] <= dec_val;
                    zero_a_ff          <= (dec_val == 16'h0000);
                  end
                end
                default: ;
              endcase
            end
          endcase
        end
        // Access strobe cycle
        S_ACC: begin
          if (dmem_we_ff) begin
            if (op_ff == `OP_PUSH || op_ff == `OP_PUSHA)
              {ext_ff[3'h7], gpr_ff[`IDX_SP]} <= sp22 + 22'h000002;
            if (step_ff == last_step) begin
              state_ff <= S_IDLE;
              ready_ff <= 1'b1;
            end else begin
              step_ff  <= step_ff + 2'd1;
              state_ff <= S_EXEC;
            end
          end else begin
            state_ff <= S_RDATA;
          end
        end
        // Read data returned
        S_RDATA: begin
          state_ff <= S_EXEC;
          step_ff  <= step_ff + 2'd1;
          case (op_ff)
            `OP_POP, `OP_POPA: begin
              if (item_ext)
                ext_ff[item_reg[2:0]] <= dmem_rdata_in[5:0];
              else
                gpr_ff[item_reg] <= dmem_rdata_in;
            end
            `OP_LDC: gpr_ff[rn_ff] <= pmem_rdata_in;
            `OP_BIT_TEST: test_flag_ff <= ~bit_old;
            `OP_BIT_CLEAR, `OP_BITS, `OP_BIT_COMPLEMENT: begin
              dmem_wdata_ff <= {8'h00, bit_new};
              dmem_we_ff    <= 1'b1;
              step_ff       <= step_ff;
              state_ff      <= S_ACC;
            end
            default: gpr_ff[byte_reg] <= {8'h00, dmem_rdata_in[7:0]};
          endcase
          if (finish) begin
            state_ff <= S_IDLE;
            ready_ff <= 1'b1;
          end
        end
        default: begin
          state_ff <= S_IDLE;
          ready_ff <= 1'b1;
        end
      endcase
    end
  end

  // Program counter and delayed branch tracking
  always @(posedge mclk_in) begin
    if (!resetn_in) begin
      pc_ff        <= `PC_RESET;
      pend_ff      <= 1'b0;
      pend_kind_ff <= `PK_ALWAYS;
      pend_tgt_ff  <= 22'h000000;
    end else if (finish) begin
      if (pend_ff) begin
        pend_ff <= 1'b0;
        pc_ff   <= pend_go ? pend_tgt_ff : pc_ff + {19'h00000, ilen};
      end else if (delayed) begin
        pend_ff      <= 1'b1;
        pend_kind_ff <= pkind;
        pend_tgt_ff  <= br_tgt;
        pc_ff        <= pc_ff + {19'h00000, ilen};
      end else if (br_now) begin
        pc_ff <= br_tgt;
      end else begin
        pc_ff <= pc_ff + {19'h00000, ilen};
      end
    end
  end

  // Output drive
  assign ready_out       = ready_ff;
  assign retire_out      = retire_ff;
  assign dmem_addr_out   = dmem_addr_ff;
  assign dmem_wdata_out  = dmem_wdata_ff;
  assign dmem_re_out     = dmem_re_ff;
  assign dmem_we_out     = dmem_we_ff;
  assign dmem_byte_out   = dmem_byte_ff;
  assign pmem_addr_out   = pmem_addr_ff;
  assign pmem_re_out     = pmem_re_ff;
  assign gpr_val_out     = gpr_val_ff;
  assign ext_val_out     = ext_val_ff;
  assign pc_out          = pc_ff;
  assign test_flag_out   = test_flag_ff;
  assign loop_zero_a_out = zero_a_ff;
  assign loop_zero_b_out = zero_b_ff;

endmodule

//--- cpu_mem_model.sv
// Behavioural data and program memories facing the execution unit
`timescale 1ns/1ps
module cpu_mem_model (
  input  wire        mclk_in,
  input  wire [21:0] dmem_addr_in,
  input  wire [15:0] dmem_wdata_in,
  input  wire        dmem_re_in,
  input  wire        dmem_we_in,
  input  wire        dmem_byte_in,
  output reg  [15:0] dmem_rdata_out,
  input  wire [21:0] pmem_addr_in,
  input  wire        pmem_re_in,
  output reg  [15:0] pmem_rdata_out
);
  reg  [7:0] m [0:1023];            // Data bytes, address aliased to 10 bits
  wire [9:0] a = dmem_addr_in[9:0]; // Byte index
  initial {dmem_rdata_out, pmem_rdata_out} = 32'hA5A5_5A5A;
  // One-cycle answer; stale data is inverted so it never looks valid
  always @(posedge mclk_in) begin
    dmem_rdata_out <= dmem_re_in ? {m[a + 10'h001], m[a]} : ~dmem_rdata_out;
    pmem_rdata_out <= pmem_re_in ? {pmem_addr_in[7:0] ^ 8'h5A, pmem_addr_in[7:0]} : ~pmem_rdata_out;
    if (dmem_we_in) m[a] <= dmem_wdata_in[7:0];
    if (dmem_we_in && !dmem_byte_in) m[a + 10'h001] <= dmem_wdata_in[15:8];
  end
endmodule

//--- cpu_exec_unit_monitor.sv
// Port checker for the execution unit
`timescale 1ns/1ps
`include "cpu_exec_map.vh"
module cpu_exec_unit_monitor (
  input wire        mclk_in,
  input wire        resetn_in,
  input wire        instr_valid_in,
  input wire [4:0]  op_in,
  input wire        ready_out,
  input wire        retire_out,
  input wire [15:0] dmem_wdata_out,
  input wire        dmem_re_out,
  input wire        dmem_we_out,
  input wire        dmem_byte_out,
  input wire        pmem_re_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);
  wire tk = ready_out && instr_valid_in; // Instruction taken
  sequence rd_s; dmem_re_out && dmem_byte_out; endsequence
  sequence wr_s; dmem_we_out && dmem_byte_out; endsequence
  a_store_low_byte: assert property (wr_s |-> dmem_wdata_out[15:8] == 8'h00) else $error("byte store high");
  a_push_write_first: assert property (tk && op_in == `OP_PUSH |-> ##2 dmem_we_out && !dmem_byte_out)
    else $error("push write");
  a_pop_read_first: assert property (tk && op_in == `OP_POP |-> ##2 dmem_re_out && !dmem_byte_out)
    else $error("pop read");
  a_byte_load_read: assert property (tk && op_in == `OP_LDB_D4 |-> ##2 rd_s ##2 retire_out)
    else $error("byte load");
  a_pmem_fetch: assert property (tk && op_in == `OP_LDC |-> ##2 pmem_re_out && !dmem_re_out)
    else $error("pmem read");
  a_bit_rmw_order: assert property (tk && op_in inside {`OP_BIT_CLEAR, `OP_BITS, `OP_BIT_COMPLEMENT} |-> ##2 rd_s ##2 wr_s)
    else $error("bit rmw");
  a_bit_test_nowrite: assert property (tk && op_in == `OP_BIT_TEST |-> ##1 !dmem_we_out [*4])
    else $error("bit test write");
  a_imm_retire: assert property (tk && op_in inside {`OP_LDI8, `OP_LDI16, `OP_LDI22} |-> ##1 !ready_out ##1 retire_out)
    else $error("imm retire");
endmodule
bind cpu_exec_unit cpu_exec_unit_monitor u_mon (.mclk_in, .resetn_in, .instr_valid_in, .op_in, .ready_out,
  .retire_out, .dmem_wdata_out, .dmem_re_out, .dmem_we_out, .dmem_byte_out, .pmem_re_out);

//--- cpu_exec_unit_test.sv
// Self-checking bench for the execution unit
`timescale 1ns/1ps
`include "cpu_exec_map.vh"
module cpu_exec_unit_test;
  reg         mclk_in = 0, resetn_in = 0, instr_valid_in = 0, pair_in = 0, tflag_load_in = 0, tflag_val_in = 0;
  reg  [4:0]  op_in = 0;
  reg  [1:0]  cond_in = 0;
  reg  [3:0]  rn_in = 0, rm_in = 0, reg_sel_in = 0, ext_cond_in = 4'h4;
  reg  [2:0]  ai_in = 0;
  reg  [21:0] imm_in = 0;
  wire        ready_out, retire_out, dmem_re_out, dmem_we_out, dmem_byte_out, pmem_re_out;
  wire        test_flag_out, loop_zero_a_out, loop_zero_b_out;
  wire [21:0] dmem_addr_out, pmem_addr_out, pc_out;
  wire [15:0] dmem_wdata_out, dmem_rdata_in, pmem_rdata_in, gpr_val_out;
  wire [5:0]  ext_val_out;
  integer     n_mismatch = 0, num_checks = 0, cyc = 0, i;
  cpu_exec_unit u_dut (.mclk_in, .resetn_in, .instr_valid_in, .op_in, .cond_in, .pair_in, .rn_in, .rm_in,
    .ai_in, .imm_in, .ready_out, .retire_out, .dmem_addr_out, .dmem_wdata_out, .dmem_re_out, .dmem_we_out,
    .dmem_byte_out, .dmem_rdata_in, .pmem_addr_out, .pmem_re_out, .pmem_rdata_in, .ext_cond_in,
    .tflag_load_in, .tflag_val_in, .reg_sel_in, .gpr_val_out, .ext_val_out, .pc_out, .test_flag_out,
    .loop_zero_a_out, .loop_zero_b_out);
  cpu_mem_model u_mem (.mclk_in, .dmem_addr_in(dmem_addr_out), .dmem_wdata_in(dmem_wdata_out),
    .dmem_re_in(dmem_re_out), .dmem_we_in(dmem_we_out), .dmem_byte_in(dmem_byte_out),
    .dmem_rdata_out(dmem_rdata_in), .pmem_addr_in(pmem_addr_out), .pmem_re_in(pmem_re_out),
    .pmem_rdata_out(pmem_rdata_in));
  initial forever #50 mclk_in = ~mclk_in;
  // Hang guard
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin n_mismatch++; print_verdict; end
  end
  task print_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task ck(input string n, input [21:0] e, input [21:0] g);
    num_checks++;
    if (g !== e) begin n_mismatch++; $display("MISMATCH %s expected %h seen %h", n, e, g); end
  endtask
  // Issue one instruction and wait for its retire pulse
  task ex(input [4:0] o, input [1:0] c, input [3:0] n, m, input [2:0] a, input [21:0] v);
    @(negedge mclk_in);
    {op_in, cond_in, rn_in, rm_in, ai_in, imm_in, instr_valid_in} = {o, c, n, m, a, v, 1'b1};
    @(negedge mclk_in) instr_valid_in = 0;
    for (i = 0; i < 20 && retire_out !== 1'b1; i++) @(negedge mclk_in);
  endtask
  // Observe a register; x selects the extension part
  task rg(input string n, input [3:0] s, input [21:0] e, input x);
    @(negedge mclk_in) reg_sel_in = s;
    repeat (2) @(negedge mclk_in);
    ck(n, e, x ? {16'h0, ext_val_out} : {6'h0, gpr_val_out});
  endtask
  task pc(input [21:0] e);
    @(negedge mclk_in) ck("pc", e, pc_out);
  endtask
  initial begin
    u_mem.m[10'h334] = 8'hF0;
    repeat (2) @(negedge mclk_in);
    resetn_in = 1;
    ex(`OP_LDI22, 0, 0, 0, 0, 22'h100);
    ex(`OP_LDI16, 0, 1, 0, 0, 22'h1234);
    ex(`OP_STB_D4, 0, 1, 0, 0, 22'hF); ck("m10f", 8'h34, u_mem.m[10'h10F]);
    ex(`OP_LDB_D4, 0, 3, 0, 0, 22'hF); rg("r3", 3, 22'h34, 0);
    ex(`OP_STB_D16, 0, 1, 0, 0, 22'hFFFF); ck("m0ff", 8'h34, u_mem.m[10'h0FF]);
    ex(`OP_LDI16, 0, 0, 0, 0, 22'hC7);
    ex(`OP_STB_BASE, 0, 0, 0, 0, 22'hFF); ck("m1ff", 8'hC7, u_mem.m[10'h1FF]);
    ex(`OP_LDI16, 0, 4, 0, 0, 22'h8020);
    ex(`OP_STB_IDX, 0, 0, 4, 0, 0); ck("addr", 22'h8120, dmem_addr_out);
    ex(`OP_LDC, 0, 2, 0, 0, 0); rg("r2", 2, 22'h5A00, 0);
    ex(`OP_LDI8, 0, 2, 0, 0, 22'h3FFFAB); rg("r2", 2, 22'hAB, 0);
    $display("byte test done");
    ex(`OP_LDI22, 0, 7, 0, 0, 22'h200);
    pair_in = 1;
    ex(`OP_PUSH, 0, 1, 0, 0, 0); ck("push", 22'h1234, {u_mem.m[513], u_mem.m[512]});
    ck("push2", 22'hC7, {u_mem.m[515], u_mem.m[514]});
    rg("sp", 15, 22'h204, 0);
    ex(`OP_POP, 0, 5, 2, 0, 0); rg("r5", 5, 22'hC7, 0); rg("r2", 2, 22'h1234, 0);
    pair_in = 0;
    ex(`OP_LDI22, 0, 1, 0, 0, 22'h3ABEEF);
    ex(`OP_PUSHA, 0, 1, 0, 0, 0); ck("pusha", 22'h3ABEEF, {u_mem.m[514], u_mem.m[513], u_mem.m[512]});
    ck("pushz", 0, u_mem.m[515]);
    ex(`OP_POPA, 0, 2, 0, 0, 0); rg("e2", 2, 22'h3A, 1); rg("r10", 10, 22'hBEEF, 0);
    $display("stack test done");
    ex(`OP_BIT_CLEAR, 0, 0, 0, 4, 4); ex(`OP_BITS, 0, 0, 0, 0, 0); ex(`OP_BIT_COMPLEMENT, 0, 0, 0, 7, 7);
    ck("bits", 8'h61, u_mem.m[10'h334]);
    ex(`OP_BIT_TEST, 0, 0, 0, 7, 7); ck("tflag", 1, test_flag_out);
    ex(`OP_BIT_TEST, 0, 0, 0, 0, 0); ck("tflag", 0, test_flag_out);
    $display("bit test done");
    ex(`OP_JMPA, `COND_ALWAYS, 0, 0, 0, 22'h1000); pc(22'h1000);
    ex(`OP_BR, `COND_ALWAYS, 0, 0, 0, 22'h3FF); pc(22'h1000);
    ex(`OP_BR, `COND_TSET, 0, 0, 0, 22'h10); pc(22'h1002);
    ex(`OP_BR, `COND_TCLR, 0, 0, 0, 22'h10); pc(22'h1024);
    ex(`OP_JMPA, `COND_CALL, 0, 0, 0, 22'h2000); pc(22'h2000); rg("link", 14, 22'h1028, 0);
    ex(`OP_DELAYED_SUBROUTINE_BRANCH, 0, 0, 0, 0, 22'h10); ex(`OP_NOP, 0, 0, 0, 0, 0); pc(22'h2022); rg("link", 14, 22'h2004, 0);
    ex(`OP_DELAYED_RETURN, 0, 0, 0, 0, 0); ex(`OP_NOP, 0, 0, 0, 0, 0); pc(22'h2004);
    ex(`OP_BREC, 2, 0, 0, 0, 22'h8); pc(22'h2016);
    ex(`OP_BREC, 1, 0, 0, 0, 22'h8); pc(22'h2018);
    ex(`OP_LDI16, 0, 6, 0, 0, 22'h1);
    ex(`OP_LOOP_BRANCH, 0, 0, 0, 0, 22'h7F); ex(`OP_NOP, 0, 0, 0, 0, 0); pc(22'h2020);
    ck("zero_a", 1, loop_zero_a_out);
    ex(`OP_JMPI, `COND_CALL, 0, 0, 0, 0); pc(22'h100); rg("link", 14, 22'h2022, 0);
    ex(`OP_LDI8, 0, 7, 0, 0, 1); ex(`OP_LOOP_BRANCH, 1, 0, 0, 0, 22'h7E); ex(`OP_NOP, 0, 0, 0, 0, 0); pc(22'h106);
    ck("zero_b", 1, loop_zero_b_out);
    ex(`OP_BRD, `COND_TSET, 0, 0, 0, 22'h10); ex(`OP_BIT_TEST, 0, 0, 0, 4, 4); pc(22'h128);
    $display("branch test done");
    print_verdict;
  end
endmodule
